// ==== logic/pmc_top.sv ====
// Push-motion input logic: pulse accumulation, push-current select and ramp,
// torque-limit and positioning-complete outputs, AXI4-Lite register slave.
// Assumes fb_pos_in comes from encoder logic on aclk; pins are asynchronous.
//
// Functional notes
// - Positioning-complete stays low while the stopped deviation lies outside the band.
// - A signed offset of -1.8 to 1.8 degrees, zero after reset, shifts the judged position.
// - Mode bit 0 selects positioning and 1 selects push-motion, positioning after reset.
// - In push mode the four shared pins become push enable and select bits 0, 1 and 2.
// - Push-motion starts only in push mode with push enable active and pulses arriving.
// - Pulses keep accumulating in the command position while the shaft is blocked.
// - Eight push-current settings each hold 0.0 to 100.0 percent of rated current.
// - Their reset values are 30.0 up to 100.0 percent in steps of 10.0.
// - The select pins form a binary index with bit 2 as the most significant bit.
// - The selected setting is the current limit while push enable is active.
// - The torque-limit output is high for as long as push-motion is in progress.
// - Current ramps up at about 0.9 %/ms and down at about 1.8 %/ms.
// - Cutback to standstill current is suppressed while push enable is active.
`timescale 1ns/100ps
`include "pmc_consts.svh"
module pmc_top #(
    parameter int CNT_PER_REV = 1000,
    parameter int UP_CYC = `PMC_UP_STEP_NS / `PMC_CLK_NS,
    parameter int DN_CYC = `PMC_DN_STEP_NS / `PMC_CLK_NS,
    parameter int SETTLE_CYC = `PMC_SETTLE_NS / `PMC_CLK_NS,
    parameter int CUTBACK_CYC = `PMC_CUTBACK_NS / `PMC_CLK_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fwd_pulse_in,
    input wire logic rev_pulse_in,
    input wire logic deviation_clear_in,
    input wire logic res_sel_push_en_in,
    input wire logic push_sel_bit0,
    input wire logic push_sel_bit1,
    input wire logic push_sel_bit2,
    input wire pmc_pkg::pmc_pos_t fb_pos_in,
    output logic torque_limit_out,
    output logic pos_complete_out,
    output pmc_pkg::pmc_pct_t current_limit_out
);
    localparam int NPIN = 7;
    localparam logic signed [31:0] OFF_LIM = 32'(`PMC_OFF_LIM);

    logic [NPIN-1:0] pins, s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
    pmc_pkg::pmc_mode_t mode_reg;
    logic signed [7:0] off_reg;
    logic [15:0] band_reg;
    pmc_pkg::pmc_pct_t run_cur_reg, stop_cur_reg, target;
    pmc_pkg::pmc_pct_t push_cur_reg [8];
    pmc_pkg::pmc_pos_t cmd_pos_reg, off_cnt, dev, dev_abs;
    pmc_pkg::pmc_push_state_t st_reg, st_next;
    logic [31:0] idle_reg;
    logic push_on, push_en, fwd_rise, rev_rise, pulse, resync, settled, cutback;
    logic [2:0] sel;
    logic aw_full, w_full, aw_full_nx, w_full_nx, do_wr, wr_hit, rd_hit;
    logic [7:0] aw_addr;
    logic [31:0] wmerged, rd_word, rd_cur;

    // Three-stage pin synchronisers; a level counts once stages two and three agree
    assign pins = {push_sel_bit2, push_sel_bit1, push_sel_bit0, res_sel_push_en_in,
                   deviation_clear_in, rev_pulse_in, fwd_pulse_in};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    s3_reg[gi] <= 1'b0;
                    filt_reg[gi] <= 1'b0;
                    filt_d_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= pins[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        filt_reg[gi] <= s3_reg[gi];
                    end
                    filt_d_reg[gi] <= filt_reg[gi];
                end
            end
        end
    endgenerate

    // Shared pins change meaning with the input mode
    assign push_en = (mode_reg == pmc_pkg::PMC_MODE_PUSH) && filt_reg[3];
    assign sel = {filt_reg[6], filt_reg[5], filt_reg[4]};
    assign push_on = push_en;
    assign fwd_rise = filt_reg[0] && !filt_d_reg[0];
    assign rev_rise = filt_reg[1] && !filt_d_reg[1];
    assign pulse = fwd_rise || rev_rise;
    assign resync = (filt_reg[2] && !filt_d_reg[2]) ||
        ((mode_reg == pmc_pkg::PMC_MODE_POSITION) && filt_reg[6] && !filt_d_reg[6]);

    // Command position counts every pulse, also while the load holds the shaft
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_pos_reg <= '0;
        end else if (resync) begin
            cmd_pos_reg <= fb_pos_in;
        end else if (fwd_rise && !rev_rise) begin
            cmd_pos_reg <= cmd_pos_reg + 32'sh1;
        end else if (rev_rise && !fwd_rise) begin
            cmd_pos_reg <= cmd_pos_reg - 32'sh1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_reg <= '0;
        end else if (pulse) begin
            idle_reg <= '0;
        end else if (idle_reg < 32'(CUTBACK_CYC)) begin
            idle_reg <= idle_reg + 32'h1;
        end
    end
    assign settled = idle_reg >= 32'(SETTLE_CYC);
    assign cutback = (idle_reg >= 32'(CUTBACK_CYC)) && !push_en;

    // Push starts on the first pulse after enable in push mode
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            pmc_pkg::PMC_PS_IDLE: if (push_en) st_next = pmc_pkg::PMC_PS_ARMED;
            pmc_pkg::PMC_PS_ARMED: begin
                if (!push_en) st_next = pmc_pkg::PMC_PS_IDLE;
                else if (pulse) st_next = pmc_pkg::PMC_PS_PUSH;
            end
            pmc_pkg::PMC_PS_PUSH: if (!push_en) st_next = pmc_pkg::PMC_PS_IDLE;
            default: st_next = pmc_pkg::PMC_PS_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= pmc_pkg::PMC_PS_IDLE;
            torque_limit_out <= 1'b0;
        end else begin
            st_reg <= st_next;
            torque_limit_out <= st_reg == pmc_pkg::PMC_PS_PUSH;
        end
    end

    // Push setting while enabled, never cut back then; otherwise run or standstill
    always_comb begin
        if (push_on) target = push_cur_reg[sel];
        else if (cutback) target = stop_cur_reg;
        else target = run_cur_reg;
    end

    pmc_ramp #(.UP_CYC(UP_CYC), .DN_CYC(DN_CYC)) u_ramp (
        .aclk(aclk),
        .aresetn(aresetn),
        .target(target),
        .cur(current_limit_out)
    );

    // Offset in tenths of a degree, converted to encoder counts
    assign off_cnt = (32'(off_reg) * 32'(CNT_PER_REV)) / 32'sd3600;
    assign dev = cmd_pos_reg - fb_pos_in - off_cnt;
    assign dev_abs = dev[31] ? -dev : dev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_complete_out <= 1'b0;
        end else begin
            pos_complete_out <= settled && (dev_abs <= 32'(band_reg));
        end
    end

    // AXI4-Lite write path: address and data taken in any order
    assign do_wr = aw_full && w_full && !s_axi_bvalid;
    assign aw_full_nx = (aw_full || (s_axi_awvalid && s_axi_awready)) &&
        !(s_axi_bvalid && s_axi_bready);
    assign w_full_nx = (w_full || (s_axi_wvalid && s_axi_wready)) &&
        !(s_axi_bvalid && s_axi_bready);
    assign wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= `PMC_A_PUSH7) &&
        (aw_addr != `PMC_A_STATUS) && (aw_addr != `PMC_A_CMD_POS) &&
        (aw_addr != `PMC_A_CUR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_addr <= '0;
        end else begin
            aw_full <= aw_full_nx;
            w_full <= w_full_nx;
            s_axi_awready <= !aw_full_nx;
            s_axi_wready <= !w_full_nx;
            if (s_axi_awvalid && s_axi_awready) aw_addr <= s_axi_awaddr;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
    end

    always_comb begin
        case (aw_addr)
            `PMC_A_CTRL: rd_cur = {31'h0, mode_reg};
            `PMC_A_OFFSET: rd_cur = 32'(off_reg);
            `PMC_A_BAND: rd_cur = {16'h0, band_reg};
            `PMC_A_RUN_CUR: rd_cur = {22'h0, run_cur_reg};
            `PMC_A_STOP_CUR: rd_cur = {22'h0, stop_cur_reg};
            default: rd_cur = {22'h0, push_cur_reg[aw_addr[4:2]]};
        endcase
        for (int i = 0; i < 4; i++) begin
            wmerged[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] : rd_cur[8*i +: 8];
        end
    end

    // Mode, offset, band and current registers; percentages clamp at 100.0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= pmc_pkg::PMC_MODE_POSITION;
            off_reg <= 8'sh0;
            band_reg <= `PMC_BAND_RST;
            run_cur_reg <= `PMC_RUN_RST;
            stop_cur_reg <= `PMC_STOP_RST;
        end else if (do_wr) begin
            case (aw_addr)
                `PMC_A_CTRL: mode_reg <= pmc_pkg::pmc_mode_t'(wmerged[`PMC_CTRL_MODE]);
                `PMC_A_OFFSET: begin
                    if ($signed(wmerged) > OFF_LIM) off_reg <= `PMC_OFF_LIM;
                    else if ($signed(wmerged) < -OFF_LIM) off_reg <= -`PMC_OFF_LIM;
                    else off_reg <= wmerged[7:0];
                end
                `PMC_A_BAND: band_reg <= wmerged[15:0];
                `PMC_A_RUN_CUR: run_cur_reg <= (wmerged > 32'(`PMC_CUR_MAX)) ?
                    `PMC_CUR_MAX : wmerged[9:0];
                `PMC_A_STOP_CUR: stop_cur_reg <= (wmerged > 32'(`PMC_CUR_MAX)) ?
                    `PMC_CUR_MAX : wmerged[9:0];
                default: ;
            endcase
        end
    end

    generate
        for (gi = 0; gi < 8; gi++) begin : g_push
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    push_cur_reg[gi] <= 10'(`PMC_PUSH_RST_BASE + gi * `PMC_PUSH_RST_STEP);
                end else if (do_wr && aw_addr == 8'(`PMC_A_PUSH0 + 4 * gi)) begin
                    push_cur_reg[gi] <= (wmerged > 32'(`PMC_CUR_MAX)) ?
                        `PMC_CUR_MAX : wmerged[9:0];
                end
            end
        end
    endgenerate

    // AXI4-Lite read path: one outstanding read, data one cycle after address
    assign rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `PMC_A_PUSH7);
    always_comb begin
        case (s_axi_araddr)
            `PMC_A_CTRL: rd_word = {31'h0, mode_reg};
            `PMC_A_OFFSET: rd_word = 32'(off_reg);
            `PMC_A_BAND: rd_word = {16'h0, band_reg};
            `PMC_A_RUN_CUR: rd_word = {22'h0, run_cur_reg};
            `PMC_A_STOP_CUR: rd_word = {22'h0, stop_cur_reg};
            `PMC_A_STATUS: rd_word = {23'h0, cutback, 1'b0, sel, 1'b0, push_en,
                                      pos_complete_out, torque_limit_out};
            `PMC_A_CMD_POS: rd_word = cmd_pos_reg;
            `PMC_A_CUR: rd_word = {22'h0, current_limit_out};
            default: rd_word = rd_hit ? {22'h0, push_cur_reg[s_axi_araddr[4:2]]} : 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_band_gate: assert property ((dev_abs > 32'(band_reg)) |=> !pos_complete_out)
        else $error("complete high outside band");
    a_offset_range: assert property ((off_reg <= 8'sh12) && (off_reg >= -8'sh12))
        else $error("offset out of range");
    a_mode_default: assert property ($past(!aresetn) |->
        mode_reg == pmc_pkg::PMC_MODE_POSITION && off_reg == 8'sh0)
        else $error("mode or offset reset value wrong");
    a_push_start: assert property ((st_reg == pmc_pkg::PMC_PS_PUSH) |->
        $past(push_en) && (mode_reg == pmc_pkg::PMC_MODE_PUSH))
        else $error("push without mode and enable");
    a_pulse_accum: assert property ((st_reg == pmc_pkg::PMC_PS_PUSH) && fwd_rise &&
        !rev_rise && !resync |=> cmd_pos_reg == $past(cmd_pos_reg) + 32'sh1)
        else $error("pulse lost during push");
    a_push_dflt: assert property ($past(!aresetn) |-> push_cur_reg[0] == 10'h12C &&
        push_cur_reg[7] == 10'h3E8)
        else $error("push current reset value wrong");
    a_push_max: assert property (push_cur_reg[3] <= 10'h3E8)
        else $error("push current above full scale");
    a_push_target: assert property (push_en |-> target == push_cur_reg[sel])
        else $error("target not the selected push current");
    a_tq_follow: assert property ((st_reg == pmc_pkg::PMC_PS_PUSH) |=> torque_limit_out)
        else $error("torque limit missing during push");
    a_tq_end: assert property (!push_en ##1 !push_en |=> !torque_limit_out)
        else $error("torque limit stays after push");
    a_no_cutback: assert property (push_en && idle_reg >= 32'(CUTBACK_CYC) |->
        !cutback && target == push_cur_reg[sel])
        else $error("cutback during push");
    a_sel_live: assert property (push_en && $changed(sel) && $past(push_en) |->
        target == push_cur_reg[sel])
        else $error("select change not applied");

    c_push_run: cover property ((st_reg == pmc_pkg::PMC_PS_ARMED) ##1
        (st_reg == pmc_pkg::PMC_PS_PUSH));
    c_complete: cover property ($rose(pos_complete_out));
    c_sel_top: cover property (push_en && sel == 3'h7);
    c_write_bad: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// ==== include/pmc_consts.svh ====
// Offsets, field positions, reset values and timing figures of the push-motion block.
// Assumes a 50 MHz aclk; register offsets are byte addresses on AXI4-Lite.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_A_CTRL 8'h00
`define PMC_A_OFFSET 8'h04
`define PMC_A_BAND 8'h08
`define PMC_A_RUN_CUR 8'h0C
`define PMC_A_STOP_CUR 8'h10
`define PMC_A_STATUS 8'h14
`define PMC_A_CMD_POS 8'h18
`define PMC_A_CUR 8'h1C
`define PMC_A_PUSH0 8'h20
`define PMC_A_PUSH7 8'h3C

`define PMC_CTRL_MODE 0
`define PMC_ST_PUSHING 0
`define PMC_ST_COMPLETE 1
`define PMC_ST_PUSH_EN 2
`define PMC_ST_SEL_LSB 4
`define PMC_ST_CUTBACK 8

`define PMC_CUR_MAX 10'h3E8
`define PMC_PUSH_RST_BASE 10'h12C
`define PMC_PUSH_RST_STEP 10'h064
`define PMC_RUN_RST 10'h3E8
`define PMC_STOP_RST 10'h1F4
`define PMC_OFF_LIM 8'h12
`define PMC_BAND_RST 16'h0004
`define PMC_DEG_TENTHS 3600

`define PMC_CLK_NS 20
`define PMC_UP_STEP_NS 111111
`define PMC_DN_STEP_NS 55555
`define PMC_SETTLE_NS 1000000
`define PMC_CUTBACK_NS 100000000

`endif

// ==== include/pmc_pkg.sv ====
// Types shared by the push-motion block.
// Assumes pmc_consts.svh for all numeric figures.
package pmc_pkg;
    typedef logic [9:0] pmc_pct_t;
    typedef logic signed [31:0] pmc_pos_t;
    typedef enum logic {PMC_MODE_POSITION, PMC_MODE_PUSH} pmc_mode_t;
    typedef enum logic [1:0] {PMC_PS_IDLE, PMC_PS_ARMED, PMC_PS_PUSH} pmc_push_state_t;
endpackage

// ==== logic/pmc_ramp.sv ====
// Motor current ramp: moves one 0.1 % unit per step period toward the target.
// Assumes target comes from logic on the same clock.
`timescale 1ns/100ps
module pmc_ramp #(
    parameter int UP_CYC = 5555,
    parameter int DN_CYC = 2777
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pmc_pkg::pmc_pct_t target,
    output pmc_pkg::pmc_pct_t cur
);
    logic [31:0] cnt_reg;
    logic going_up;
    logic [31:0] limit;

    assign going_up = target > cur;
    assign limit = going_up ? 32'(UP_CYC - 1) : 32'(DN_CYC - 1);

    // One unit per period: up at the slow rate, down at twice that
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= '0;
            cnt_reg <= '0;
        end else if (target == cur) begin
            cnt_reg <= '0;
        end else if (cnt_reg > limit) begin
            // Direction flipped mid-count with the count past the new, shorter limit: restart the period
            cnt_reg <= '0;
        end else if (cnt_reg == limit) begin
            cnt_reg <= '0;
            cur <= going_up ? cur + 10'h001 : cur - 10'h001;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ramp_unit: assert property (cur != $past(cur) |->
        (cur == $past(cur) + 10'h001) || (cur == $past(cur) - 10'h001))
        else $error("ramp moved by more than one unit");
    a_ramp_period: assert property ($changed(cur) |->
        $past(cnt_reg) == ($past(going_up) ? 32'(UP_CYC - 1) : 32'(DN_CYC - 1)))
        else $error("ramp stepped at the wrong period");
    a_ramp_toward: assert property ((cur > $past(cur)) |-> $past(target) > $past(cur))
        else $error("ramp moved away from target");
endmodule

// ==== tb/pmc_host.sv ====
// Host pulse controller model: drives pulse, clear, push enable and select pins.
// Assumes the bench calls its tasks; every pin changes just after a rising aclk edge.
`timescale 1ns/100ps
module pmc_host (
    input wire logic aclk,
    output logic fwd_pulse_in,
    output logic rev_pulse_in,
    output logic deviation_clear_in,
    output logic res_sel_push_en_in,
    output logic push_sel_bit0,
    output logic push_sel_bit1,
    output logic push_sel_bit2
);
    initial begin
        fwd_pulse_in = 1'b0;
        rev_pulse_in = 1'b0;
        deviation_clear_in = 1'b0;
        res_sel_push_en_in = 1'b0;
        {push_sel_bit2, push_sel_bit1, push_sel_bit0} = 3'h0;
    end

    // Pulses wide and spaced enough for the pin filter; line idles low between them
    task automatic pulses(input int n, input logic rev);
        repeat (n) begin
            @(posedge aclk);
            fwd_pulse_in <= ~rev;
            rev_pulse_in <= rev;
            repeat (6) @(posedge aclk);
            fwd_pulse_in <= 1'b0;
            rev_pulse_in <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask

    // Shared pin carries push enable; select bit 2 is the most significant
    task automatic set_push(input logic en, input logic [2:0] sel);
        @(posedge aclk);
        res_sel_push_en_in <= en;
        {push_sel_bit2, push_sel_bit1, push_sel_bit0} <= sel;
    endtask

    task automatic clear();
        @(posedge aclk);
        deviation_clear_in <= 1'b1;
        repeat (6) @(posedge aclk);
        deviation_clear_in <= 1'b0;
    endtask
endmodule

// ==== tb/pmc_top_tb_top.sv ====
// Self-checking bench for the push-motion block over AXI4-Lite and its pins.
// Assumes pmc_host drives the pins; fb_pos_in stands for a blocked encoder.
`timescale 1ns/100ps
`include "pmc_consts.svh"
module pmc_top_tb_top;
    localparam int UP = 4;
    localparam int DN = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tq_out, pc;
    logic fwd, rev, dclr, pen, s0, s1, s2;
    logic [1:0] bresp, rresp, rs;
    pmc_pkg::pmc_pct_t cur;
    pmc_pkg::pmc_pos_t fb = 32'sh0;
    int bad_count = 0;
    int cmp_count = 0;

    always #10 aclk = ~aclk;

    pmc_top #(.UP_CYC(UP), .DN_CYC(DN), .SETTLE_CYC(8), .CUTBACK_CYC(20)) pmc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fwd_pulse_in(fwd), .rev_pulse_in(rev), .deviation_clear_in(dclr),
        .res_sel_push_en_in(pen), .push_sel_bit0(s0), .push_sel_bit1(s1),
        .push_sel_bit2(s2), .fb_pos_in(fb), .torque_limit_out(tq_out),
        .pos_complete_out(pc), .current_limit_out(cur));

    pmc_host pmc_host_inst (.aclk(aclk), .fwd_pulse_in(fwd), .rev_pulse_in(rev),
        .deviation_clear_in(dclr), .res_sel_push_en_in(pen), .push_sel_bit0(s0),
        .push_sel_bit1(s1), .push_sel_bit2(s2));

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Each call lets one edge pass so a released handshake is never raised in the same step
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [33:0] e);
        axi_rd(a);
        chk(nm, e, {rs, rd});
    endtask

    task automatic wait_cur(input logic [9:0] e);
        int n;
        n = 0;
        while (cur !== e && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        chk("current_limit_out", e, cur);
    endtask

    // Cycles between two successive one-unit moves of the current limit
    task automatic step_time(input int e);
        int n;
        logic [9:0] v;
        for (int k = 0; k < 2; k++) begin
            v = cur;
            n = 0;
            while (cur === v && n < 50) begin
                @(posedge aclk);
                n++;
            end
        end
        chk("ramp step", 34'h1, (n >= e && n <= e + 1) ? 34'h1 : 34'h0);
    endtask

    task automatic t_regs();
        rchk("ctrl", `PMC_A_CTRL, 34'h0);
        rchk("offset", `PMC_A_OFFSET, 34'h0);
        for (int i = 0; i < 8; i++) begin
            rchk("push", `PMC_A_PUSH0 + 8'(4 * i), 34'(300 + 100 * i));
        end
        rchk("unmapped", 8'h40, 34'h200000000);
        axi_wr(`PMC_A_STATUS, 32'h1);
        chk("ro write", 34'h2, 34'(rs));
        axi_wr(`PMC_A_PUSH0 + 8'h0C, 32'h7FF);
        rchk("push clamp", `PMC_A_PUSH0 + 8'h0C, 34'h3E8);
        axi_wr(`PMC_A_RUN_CUR, 32'h28);
        axi_wr(`PMC_A_STOP_CUR, 32'h14);
        for (int i = 0; i < 8; i++) begin
            axi_wr(`PMC_A_PUSH0 + 8'(4 * i), 32'(50 + 10 * i));
        end
    endtask

    task automatic t_pos();
        axi_rd(`PMC_A_CMD_POS);
        pmc_host_inst.set_push(1'b1, 3'h0);
        pmc_host_inst.pulses(2, 1'b0);
        pmc_host_inst.pulses(1, 1'b1);
        chk("torque_limit_out", 34'h0, tq_out);
        rchk("cmd pos", `PMC_A_CMD_POS, {2'h0, rd + 32'h1});
        pmc_host_inst.set_push(1'b0, 3'h0);
    endtask

    task automatic t_push();
        axi_wr(`PMC_A_CTRL, 32'h1);
        wait_cur(10'h014);
        pmc_host_inst.set_push(1'b1, 3'h0);
        step_time(UP);
        wait_cur(10'h032);
        for (int i = 1; i < 8; i++) begin
            pmc_host_inst.set_push(1'b1, 3'(i));
            wait_cur(10'(50 + 10 * i));
            axi_rd(`PMC_A_STATUS);
            chk("status", 34'(32'h4 | (32'(i) << 4)), {2'h0, rd & 32'h175});
        end
        axi_rd(`PMC_A_CMD_POS);
        pmc_host_inst.pulses(3, 1'b0);
        chk("torque_limit_out", 34'h1, tq_out);
        rchk("cmd pos", `PMC_A_CMD_POS, {2'h0, rd + 32'h3});
        repeat (40) @(posedge aclk);
        chk("push current held", 34'h78, cur);
        chk("torque_limit_out", 34'h1, tq_out);
        pmc_host_inst.set_push(1'b0, 3'h7);
        repeat (10) @(posedge aclk);
        chk("torque_limit_out", 34'h0, tq_out);
        step_time(DN);
        wait_cur(10'h014);
        axi_wr(`PMC_A_CTRL, 32'h0);
    endtask

    task automatic t_cmp();
        fb <= 32'sh3E8;
        pmc_host_inst.clear();
        repeat (20) @(posedge aclk);
        chk("pos_complete_out", 34'h1, pc);
        fb <= 32'sh3E1;
        repeat (4) @(posedge aclk);
        chk("pos_complete_out", 34'h0, pc);
        axi_wr(`PMC_A_OFFSET, 32'h12);
        repeat (4) @(posedge aclk);
        chk("pos_complete_out", 34'h1, pc);
        axi_wr(`PMC_A_OFFSET, 32'hFFFFFFEE);
        repeat (4) @(posedge aclk);
        chk("pos_complete_out", 34'h0, pc);
        axi_wr(`PMC_A_OFFSET, 32'h20);
        rchk("offset clamp", `PMC_A_OFFSET, 34'h12);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_pos();
        t_push();
        t_cmp();
        print_verdict();
    end

    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end
endmodule
